/* rtl/cids_pkg.sv */
/*
 * Shared constants and types for the clock input divider and sync controller.
 * Assumes an 8-bit register port with 10-bit byte offsets and three channels.
 */
package cids_pkg;
    // Register port widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 3;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_RATIO = 10'h1e0;
    localparam logic [ADDR_W-1:0] OFF_INSEL = 10'h1e1;
    localparam logic [ADDR_W-1:0] OFF_SYS = 10'h230;
    localparam logic [ADDR_W-1:0] OFF_UPD = 10'h232;

    // Field positions
    localparam int RATIO_LSB = 0;
    localparam int RATIO_W = 3;
    localparam int IN_PD_BIT = 4;
    localparam int OSC_IF_PD_BIT = 3;
    localparam int SRC_PD_BIT = 2;
    localparam int SEL_OSC_BIT = 1;
    localparam int BYPASS_BIT = 0;
    localparam int SYNC_PD_BIT = 2;
    localparam int DREF_PD_BIT = 1;
    localparam int SOFT_SYNC_BIT = 0;
    localparam int UPD_BIT = 0;

    // Prescaler codes
    localparam logic [RATIO_W-1:0] RATIO_RST = 3'h2;
    localparam logic [RATIO_W-1:0] RATIO_STATIC_MIN = 3'h5;
    localparam logic [RATIO_W-1:0] DIV_BASE = 3'h2;

    // Pin synchroniser order and reset levels: osc, ext, sync_n
    localparam int PIN_OSC = 0;
    localparam int PIN_EXT = 1;
    localparam int PIN_SYNC_N = 2;
    localparam int NUM_PIN = 3;
    localparam logic [NUM_PIN-1:0] PIN_RST = 3'h4;

    // Select/bypass pairs for the direct channel route
    localparam logic [1:0] SELBYP_OSC = 2'h2;
    localparam logic [1:0] SELBYP_EXT = 2'h0;

    typedef enum logic [1:0] {ROUTE_DIV, ROUTE_OSC, ROUTE_EXT} cids_route_e;
    typedef enum logic {UPD_IDLE, UPD_COPY} cids_upd_e;

    // One full set of programmable settings
    typedef struct packed {
        logic [RATIO_W-1:0] ratio;
        logic in_pd;
        logic osc_if_pd;
        logic src_pd;
        logic sel_osc;
        logic bypass;
        logic sync_pd;
        logic dref_pd;
        logic soft_sync;
    } cids_cfg_s;

    localparam cids_cfg_s CFG_RST = '{ratio: RATIO_RST, default: 1'b0};
endpackage

/* rtl/cids_ctrl.sv */
/*
 * Clock input front end control: source select, prescaler, power-downs,
 * software sync and buffered-to-active register transfer.
 * Assumes a single core clock; clock and sync pins are asynchronous and are
 * sampled, so the input clocks must be well below half the core clock rate.
 */
// Overview of operation
// - Prescaler codes 0..4 divide by 2..6, reset code 2 divides by 4, codes 5..7 hold the output static.
// - Input-control bit 4 powers down the whole clock input section, buffer, prescaler and tree.
// - Input-control bit 3 powers down the oscillator-to-distribution interface.
// - Input-control bit 2 powers down both the oscillator and the external clock input.
// - Input-control bit 1 feeds the prescaler from the external input at 0 and the oscillator at 1.
// - Input-control bit 0 bypasses the prescaler when set.
// - System bit 2 powers down the sync circuitry.
// - System bit 1 powers down the distribution reference.
// - The soft sync bit acts as an inverted sync pin, holding selected channels static while 1.
// - A 1-to-0 fall of the soft sync bit triggers a sync of the selected channels.
// - Writing 1 to update bit 0 copies all buffered values to the active set, which software must do.
// - The update bit clears itself after the transfer.
// - A direct-output channel takes the oscillator for select/bypass 10b, the external clock for 00b, else its divider.
// - A channel with its no-sync bit set ignores every chip-level sync request.
`timescale 1ns/10ps
module cids_ctrl
(
    input wire logic core_clk, // Core clock, 125 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [cids_pkg::ADDR_W-1:0] reg_addr, // Register offset
    input wire logic [cids_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [cids_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic osc_clk_pin, // Internal oscillator clock
    input wire logic ext_clk_pin, // External clock input
    input wire logic sync_n_pin, // Sync pin, active low
    input wire logic [cids_pkg::NUM_CH-1:0] ch_nosync, // Channel ignores sync
    input wire logic [cids_pkg::NUM_CH-1:0] ch_direct, // Channel direct-output option
    output logic presc_clk_out, // Prescaler output
    output logic in_section_pd, // Clock input section power-down
    output logic osc_if_pd, // Oscillator interface power-down
    output logic src_pd, // Oscillator and external input power-down
    output logic sync_pd, // Sync circuitry power-down
    output logic dist_ref_pd, // Distribution reference power-down
    output logic [cids_pkg::NUM_CH-1:0] ch_sync_hold, // Channel held static
    output logic [cids_pkg::NUM_CH-1:0] ch_sync_pulse, // Channel sync trigger
    output cids_pkg::cids_route_e [cids_pkg::NUM_CH-1:0] ch_route // Channel output source
);
    cids_pkg::cids_cfg_s buf_r;
    cids_pkg::cids_cfg_s act_r;
    cids_pkg::cids_upd_e upd_state_r;
    logic [cids_pkg::NUM_PIN-1:0] pin_meta_r;
    logic [cids_pkg::NUM_PIN-1:0] pin_s_r;
    logic sel_in;
    logic sel_prev_r;
    logic [cids_pkg::RATIO_W-1:0] div_n;
    logic [cids_pkg::RATIO_W-1:0] div_half;
    logic [cids_pkg::RATIO_W-1:0] cnt_r;
    logic div_static;
    logic hold_lvl;
    logic hold_prev_r;
    logic sync_fire;
    logic upd_req;
    logic upd_pend;
    logic [cids_pkg::DATA_W-1:0] rdata_r;
    logic [1:0] selbyp;

    // Two-flop synchronisers for the asynchronous pins
    genvar gp;
    generate
        for (gp = 0; gp < cids_pkg::NUM_PIN; gp++)
        begin : g_pin_sync
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    pin_meta_r[gp] <= cids_pkg::PIN_RST[gp];
                    pin_s_r[gp] <= cids_pkg::PIN_RST[gp];
                end
                else
                begin
                    pin_meta_r[gp] <= gp == cids_pkg::PIN_OSC ? osc_clk_pin :
                                      gp == cids_pkg::PIN_EXT ? ext_clk_pin : sync_n_pin;
                    pin_s_r[gp] <= pin_meta_r[gp];
                end
            end
        end
    endgenerate

    // Buffered settings written by software
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            buf_r <= cids_pkg::CFG_RST;
        else if (reg_wr)
        begin
            case (reg_addr)
                cids_pkg::OFF_RATIO:
                    buf_r.ratio <= reg_wdata[cids_pkg::RATIO_LSB +: cids_pkg::RATIO_W];
                cids_pkg::OFF_INSEL:
                begin
                    buf_r.in_pd <= reg_wdata[cids_pkg::IN_PD_BIT];
                    buf_r.osc_if_pd <= reg_wdata[cids_pkg::OSC_IF_PD_BIT];
                    buf_r.src_pd <= reg_wdata[cids_pkg::SRC_PD_BIT];
                    buf_r.sel_osc <= reg_wdata[cids_pkg::SEL_OSC_BIT];
                    buf_r.bypass <= reg_wdata[cids_pkg::BYPASS_BIT];
                end
                cids_pkg::OFF_SYS:
                begin
                    buf_r.sync_pd <= reg_wdata[cids_pkg::SYNC_PD_BIT];
                    buf_r.dref_pd <= reg_wdata[cids_pkg::DREF_PD_BIT];
                    buf_r.soft_sync <= reg_wdata[cids_pkg::SOFT_SYNC_BIT];
                end
                default:
                    buf_r <= buf_r;
            endcase
        end
    end

    assign upd_req = reg_wr && reg_addr == cids_pkg::OFF_UPD && reg_wdata[cids_pkg::UPD_BIT];
    assign upd_pend = upd_state_r == cids_pkg::UPD_COPY;
    // Update transfer; a new request in the copy cycle keeps it pending
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            upd_state_r <= cids_pkg::UPD_IDLE;
        else
        begin
            case (upd_state_r)
                cids_pkg::UPD_IDLE:
                    upd_state_r <= upd_req ? cids_pkg::UPD_COPY : cids_pkg::UPD_IDLE;
                cids_pkg::UPD_COPY:
                    upd_state_r <= upd_req ? cids_pkg::UPD_COPY : cids_pkg::UPD_IDLE;
                default:
                    upd_state_r <= cids_pkg::UPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            act_r <= cids_pkg::CFG_RST;
        else if (upd_pend)
            act_r <= buf_r;
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata_r <= '0;
        else if (reg_rd)
        begin
            rdata_r <= '0;
            case (reg_addr)
                cids_pkg::OFF_RATIO:
                    rdata_r[cids_pkg::RATIO_LSB +: cids_pkg::RATIO_W] <= buf_r.ratio;
                cids_pkg::OFF_INSEL:
                begin
                    rdata_r[cids_pkg::IN_PD_BIT] <= buf_r.in_pd;
                    rdata_r[cids_pkg::OSC_IF_PD_BIT] <= buf_r.osc_if_pd;
                    rdata_r[cids_pkg::SRC_PD_BIT] <= buf_r.src_pd;
                    rdata_r[cids_pkg::SEL_OSC_BIT] <= buf_r.sel_osc;
                    rdata_r[cids_pkg::BYPASS_BIT] <= buf_r.bypass;
                end
                cids_pkg::OFF_SYS:
                begin
                    rdata_r[cids_pkg::SYNC_PD_BIT] <= buf_r.sync_pd;
                    rdata_r[cids_pkg::DREF_PD_BIT] <= buf_r.dref_pd;
                    rdata_r[cids_pkg::SOFT_SYNC_BIT] <= buf_r.soft_sync;
                end
                cids_pkg::OFF_UPD:
                    rdata_r[cids_pkg::UPD_BIT] <= upd_pend;
                default:
                    rdata_r <= '0;
            endcase
        end
        else
            rdata_r <= '0;
    end
    assign reg_rdata = rdata_r;

    assign in_section_pd = act_r.in_pd;
    assign osc_if_pd = act_r.osc_if_pd;
    assign src_pd = act_r.src_pd;
    assign sync_pd = act_r.sync_pd;
    assign dist_ref_pd = act_r.dref_pd;

    assign sel_in = act_r.src_pd ? 1'b0 :
                    act_r.sel_osc ? (pin_s_r[cids_pkg::PIN_OSC] & ~act_r.osc_if_pd) :
                    pin_s_r[cids_pkg::PIN_EXT];

    assign div_n = act_r.ratio + cids_pkg::DIV_BASE;
    assign div_half = 3'((4'(div_n) + 4'h1) >> 1);
    assign div_static = act_r.ratio >= cids_pkg::RATIO_STATIC_MIN;

    // Input edge tracking
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            sel_prev_r <= 1'b0;
        else
            sel_prev_r <= sel_in;
    end

    // prescaler counter, advanced on each rising input edge, restarted by an update so it never starts past a new ratio
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || act_r.in_pd || div_static || upd_pend)
            cnt_r <= '0;
        else if (sel_in && !sel_prev_r)
            cnt_r <= cnt_r >= div_n - 3'h1 ? '0 : cnt_r + 3'h1;
    end

    // bypass, static and power-down on the output
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || act_r.in_pd)
            presc_clk_out <= 1'b0;
        else if (act_r.bypass)
            presc_clk_out <= sel_in;
        else if (div_static)
            presc_clk_out <= 1'b0;
        else
            presc_clk_out <= cnt_r < div_half;
    end

    // soft bit and pin merged as one hold level, gated
    assign hold_lvl = !act_r.sync_pd && (act_r.soft_sync || !pin_s_r[cids_pkg::PIN_SYNC_N]);
    // release of the hold triggers the sync
    assign sync_fire = hold_prev_r && !hold_lvl && !act_r.sync_pd;
    assign selbyp = {act_r.sel_osc, act_r.bypass};
    // Hold level history for release detection
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            hold_prev_r <= 1'b0;
        else
            hold_prev_r <= hold_lvl;
    end

    // Per-channel sync and route outputs
    genvar gc;
    generate
        for (gc = 0; gc < cids_pkg::NUM_CH; gc++)
        begin : g_chan
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    ch_sync_hold[gc] <= 1'b0;
                    ch_sync_pulse[gc] <= 1'b0;
                    ch_route[gc] <= cids_pkg::ROUTE_DIV;
                end
                else
                begin
                    ch_sync_hold[gc] <= hold_lvl && !ch_nosync[gc];
                    ch_sync_pulse[gc] <= sync_fire && !ch_nosync[gc];
                    if (ch_direct[gc] && selbyp == cids_pkg::SELBYP_OSC)
                        ch_route[gc] <= cids_pkg::ROUTE_OSC;
                    else if (ch_direct[gc] && selbyp == cids_pkg::SELBYP_EXT)
                        ch_route[gc] <= cids_pkg::ROUTE_EXT;
                    else
                        ch_route[gc] <= cids_pkg::ROUTE_DIV;
                end
            end
        end
    endgenerate

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_upd_write;
        upd_req;
    endsequence
    sequence s_hold_then_release;
        hold_lvl ##1 (!hold_lvl && !act_r.sync_pd);
    endsequence
    property p_div_range;
        !act_r.in_pd && !div_static |-> cnt_r < div_n;
    endproperty
    a_div_range: assert property (p_div_range) else $error("prescaler count beyond ratio");
    property p_static_low;
        div_static && !act_r.bypass ##1 div_static && !act_r.bypass |-> !presc_clk_out && cnt_r == '0;
    endproperty
    a_static_low: assert property (p_static_low) else $error("static prescaler not low");
    property p_in_pd;
        act_r.in_pd |=> !presc_clk_out;
    endproperty
    a_in_pd: assert property (p_in_pd) else $error("input section not powered down");
    property p_src_off;
        act_r.src_pd || (act_r.sel_osc && act_r.osc_if_pd) |-> !sel_in;
    endproperty
    a_src_off: assert property (p_src_off) else $error("powered-down source passes");
    property p_bypass;
        !act_r.in_pd && act_r.bypass |=> presc_clk_out == $past(sel_in);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass output mismatch");
    property p_soft_hold;
        act_r.soft_sync && !act_r.sync_pd |=> ch_sync_hold == ~$past(ch_nosync);
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("soft sync hold missing");
    property p_release;
        s_hold_then_release |=> ch_sync_pulse == ~$past(ch_nosync);
    endproperty
    a_release: assert property (p_release) else $error("sync not triggered on release");
    property p_copy;
        s_upd_write ##1 1'b1 |=> act_r == $past(buf_r);
    endproperty
    a_copy: assert property (p_copy) else $error("active set not updated");
    property p_self_clear;
        s_upd_write ##1 !upd_req |=> !upd_pend;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("update bit stuck");
    property p_nosync;
        ch_nosync != '0 |=> ((ch_sync_hold | ch_sync_pulse) & $past(ch_nosync)) == '0;
    endproperty
    a_nosync: assert property (p_nosync) else $error("no-sync channel synced");
    property p_direct_osc;
        ch_direct[0] && selbyp == cids_pkg::SELBYP_OSC |=> ch_route[0] == cids_pkg::ROUTE_OSC;
    endproperty
    a_direct_osc: assert property (p_direct_osc) else $error("direct oscillator route wrong");
    property p_upd_zero;
        !upd_pend && !upd_req |=> !upd_pend;
    endproperty
    a_upd_zero: assert property (p_upd_zero) else $error("update started without a one");
endmodule // cids_ctrl

/* verif/cids_ctrl_bench.sv */
/*
 * Self-checking bench for cids_ctrl: register port, update transfer,
 * power-downs, channel routing, prescaler ratios and sync.
 * Assumes the bench drives every pin itself; pin clocks run far below core_clk.
 */
`timescale 1ns/10ps
module cids_ctrl_bench;
    logic core_clk, rst_n, reg_wr, reg_rd, sync_n_pin, presc_clk_out;
    logic ext_clk_pin = 1'b0;
    logic osc_clk_pin = 1'b0;
    logic in_section_pd, osc_if_pd, src_pd, sync_pd, dist_ref_pd;
    logic [cids_pkg::ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, rv;
    logic [2:0] ch_nosync, ch_direct, ch_sync_hold, ch_sync_pulse;
    cids_pkg::cids_route_e [cids_pkg::NUM_CH-1:0] ch_route;
    logic [cids_pkg::ADDR_W-1:0] offs [5] = '{cids_pkg::OFF_RATIO, cids_pkg::OFF_INSEL, cids_pkg::OFF_SYS,
        cids_pkg::OFF_UPD, 10'h1e2};
    logic [7:0] msk [3] = '{8'h07, 8'h1f, 8'h07};
    logic [7:0] sb [3] = '{8'h00, 8'h02, 8'h01};
    logic [7:0] pcfg [3] = '{8'h01, 8'h02, 8'h10};
    logic [7:0] pexp [3] = '{8'h10, 8'h28, 8'h00};
    logic [7:0] bufr [4], act [4];
    int miscompares = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;
    int div_cnt = 0;
    int pcnt [3] = '{0, 0, 0};
    int snap [3];
    int per, k;

    cids_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_clk_pin(osc_clk_pin),
        .ext_clk_pin(ext_clk_pin), .sync_n_pin(sync_n_pin), .ch_nosync(ch_nosync), .ch_direct(ch_direct),
        .presc_clk_out(presc_clk_out), .in_section_pd(in_section_pd), .osc_if_pd(osc_if_pd), .src_pd(src_pd),
        .sync_pd(sync_pd), .dist_ref_pd(dist_ref_pd), .ch_sync_hold(ch_sync_hold),
        .ch_sync_pulse(ch_sync_pulse), .ch_route(ch_route));

    // Core clock, 8 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Slow pin clocks: external period 16 cycles, oscillator 20 cycles
    always @(posedge core_clk)
    begin
        div_cnt <= div_cnt + 1;
        if (div_cnt % 8 == 7)
            ext_clk_pin <= ~ext_clk_pin;
        if (div_cnt % 10 == 9)
            osc_clk_pin <= ~osc_clk_pin;
    end

    // Cycle ceiling and per-channel sync pulse tally
    always @(negedge core_clk)
    begin
        cyc_cnt++;
        for (int c = 0; c < 3; c++)
            if (ch_sync_pulse[c] === 1'b1)
                pcnt[c]++;
        if (cyc_cnt == 20000)
        begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // One write cycle, then an idle cycle; buffer model follows
    task automatic wreg(input int r, input logic [7:0] v);
        reg_wr <= 1'b1;
        reg_addr <= offs[r];
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (r < 3)
            bufr[r] = v & msk[r];
        @(posedge core_clk);
    endtask

    // One read cycle, data checked in the following cycle
    task automatic rreg(input int r, input logic [7:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= offs[r];
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("rdata", exp, reg_rdata); // register readback
        @(posedge core_clk);
    endtask

    // Update write, pending read right behind it, then cleared read
    task automatic upd();
        reg_wr <= 1'b1;
        reg_addr <= offs[3];
        reg_wdata <= 8'h01;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("pending", 8'h01, reg_rdata); // transfer pending
        act = bufr;
        @(posedge core_clk);
        rreg(3, 8'h00); // bit cleared
    endtask

    function automatic logic [1:0] rte(input int c);
        if (ch_direct[c] !== 1'b1 || act[1][1:0] == 2'h1)
            return 2'(cids_pkg::ROUTE_DIV);
        return act[1][1] ? 2'(cids_pkg::ROUTE_OSC) : 2'(cids_pkg::ROUTE_EXT);
    endfunction

    // Compare all level outputs with the active-set model
    task automatic settle();
        logic hold;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        hold = !act[2][2] && (act[2][0] || !sync_n_pin);
        chk("in_pd", 8'(act[1][4]), 8'(in_section_pd)); // input section
        chk("osc_if_pd", 8'(act[1][3]), 8'(osc_if_pd)); // oscillator interface
        chk("src_pd", 8'(act[1][2]), 8'(src_pd)); // sources
        chk("sync_pd", 8'(act[2][2]), 8'(sync_pd)); // sync circuitry
        chk("dref_pd", 8'(act[2][1]), 8'(dist_ref_pd)); // reference
        chk("hold", 8'({3{hold}} & ~ch_nosync), 8'(ch_sync_hold)); // static hold
        for (int c = 0; c < 3; c++)
            chk("route", 8'(rte(c)), 8'(ch_route[c])); // direct route
        @(posedge core_clk);
    endtask

    // Period of the prescaler output in core cycles, zero when static
    task automatic meas(input logic [7:0] exp);
        int t, first;
        logic prev;
        first = -1;
        per = 0;
        repeat (100) @(posedge core_clk);
        @(negedge core_clk);
        prev = presc_clk_out;
        for (t = 0; t < 400 && per == 0; t++)
        begin
            @(negedge core_clk);
            if (presc_clk_out === 1'b1 && prev === 1'b0)
                if (first < 0)
                    first = t;
                else
                    per = t - first;
            prev = presc_clk_out;
        end
        chk("period", exp, 8'(per)); // output period
        if (exp == 8'h00)
            chk("static_lvl", 8'h00, 8'(presc_clk_out)); // static level
        @(posedge core_clk);
    endtask

    task automatic pchk(input logic [2:0] m);
        for (int c = 0; c < 3; c++)
            chk("pulses", 8'(m[c]), 8'(pcnt[c] - snap[c])); // pulse tally
    endtask

    // Main sequence
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = 8'h00;
        sync_n_pin = 1'b1;
        ch_nosync = 3'h0;
        ch_direct = 3'h0;
        rst_n = 1'b0;
        bufr = '{8'h02, 8'h00, 8'h00, 8'h00};
        act = bufr;
        void'($urandom(62));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (k = 0; k < 5; k++)
            rreg(k, k < 3 ? bufr[k] : 8'h00); // reset values
        settle(); // reset levels
        d = 8'($urandom) & 8'h1c;
        rv = 8'($urandom) & 8'h06;
        ch_nosync <= 3'($urandom);
        ch_direct <= 3'($urandom) | 3'h1;
        wreg(1, d | 8'he0);
        wreg(2, rv);
        wreg(4, 8'hff);
        settle(); // buffered only
        rreg(1, bufr[1]); // buffer readback
        rreg(2, bufr[2]); // buffer readback
        upd(); // apply
        settle(); // after apply
        wreg(1, 8'h00);
        wreg(2, 8'h00);
        wreg(3, 8'h00);
        settle(); // zero write ignored
        upd();
        // bypass only with the external input
        for (k = 0; k < 3; k++)
        begin
            wreg(1, sb[k]);
            upd();
            settle(); // select and route
        end
        wreg(1, 8'h00);
        // static codes come last, long after the external input has settled
        for (k = 0; k < 8; k++)
        begin
            wreg(0, 8'(k));
            upd();
            meas(k < 5 ? 8'(16 * (k + 2)) : 8'h00); // ratio codes
        end
        wreg(0, 8'h00);
        for (k = 0; k < 3; k++)
        begin
            wreg(1, pcfg[k]);
            upd();
            meas(pexp[k]); // bypass, oscillator, power-down
        end
        wreg(1, 8'h00);
        ch_nosync <= 3'($urandom);
        wreg(2, 8'h01);
        upd();
        settle(); // soft hold
        snap = pcnt;
        wreg(2, 8'h00);
        upd();
        settle(); // soft hold released
        pchk(~ch_nosync); // soft release
        sync_n_pin <= 1'b0;
        settle(); // pin hold
        snap = pcnt;
        sync_n_pin <= 1'b1;
        settle(); // pin hold released
        pchk(~ch_nosync); // pin release
        wreg(2, 8'h05);
        upd();
        settle(); // hold masked
        snap = pcnt;
        wreg(2, 8'h00);
        upd();
        settle(); // levels after power-up
        pchk(3'h0); // no pulse while down
        results();
    end
endmodule // cids_ctrl_bench
